// *** core/csbos_params.svh ***
// Constants of the context-switch and serial bit output sequencer
`ifndef CSBOS_PARAMS_SVH
`define CSBOS_PARAMS_SVH
`define CSBOS_SAVED_STATUS_SLOT_OFS 16'h001e
`define CSBOS_WR14_OFS 16'h001c
`define CSBOS_WR13_OFS 16'h001a
`define CSBOS_BIT_BASE_WORKSPACE_REG_OFS 16'h0018
`define CSBOS_WORD_STEP 16'h0002
`define CSBOS_BIT_STEP 16'h0002
`define CSBOS_CNT_FULL 5'h10
`define CSBOS_CNT_ONE 5'h01
`define CSBOS_CNT_ZERO 5'h00
`define CSBOS_WORD_ZERO 16'h0000
`endif

// *** core/csbos_pkg.sv ***
// Types of the context-switch and serial bit output sequencer
package csbos_pkg;
  typedef enum logic [19:0] {
    ST_IDLE = 20'h00001,
    ST_FETCH = 20'h00002,
    ST_DECODE = 20'h00004,
    ST_OPND = 20'h00008,
    ST_ALU3 = 20'h00010,
    ST_CS4 = 20'h00020,
    ST_CS5 = 20'h00040,
    ST_CS6 = 20'h00080,
    ST_CS7 = 20'h00100,
    ST_CS8 = 20'h00200,
    ST_CS9 = 20'h00400,
    ST_CS10 = 20'h00800,
    ST_CS11 = 20'h01000,
    ST_CS12 = 20'h02000,
    ST_LD4 = 20'h04000,
    ST_LD5 = 20'h08000,
    ST_LD6 = 20'h10000,
    ST_LD7 = 20'h20000,
    ST_LD8 = 20'h40000,
    ST_LBIT = 20'h80000
  } csbos_state_t;

  typedef enum logic {
    OP_CONTEXT_SWITCH = 1'b0,
    OP_MULTI_BIT_OUTPUT = 1'b1
  } csbos_op_t;

  typedef struct packed {
    logic [15:0] addressLines;
    logic [15:0] dataLinesOut;
    logic dataLinesOe;
    logic memRead;
    logic memWrite;
  } csbos_bus_t;

  typedef struct packed {
    logic serialBitOut;
    logic serialBitStrobe;
  } csbos_serial_t;
endpackage

// *** core/csbos_sequencer.sv ***
// Bus sequencer for the context-switch and multi-bit output instructions
// Operation
// - Operand fetch inserted after cycle two, length Ns
// - Context switch: internal cycle addresses register 15
// - Write saved status to register 15
// - Internal PC+2 cycle, then write it to register 14
// - Address register 13 internally, then write old WP
// - Internal cycle, read new PC, load it
// - Output op: two internal cycles address register 12
// - Read register 12 as bit base, one internal
// - Each bit: drive serial line, pulse strobe
// - Bit address advances by two per bit
// - Exactly C bit cycles, then one final internal
// - Begin with instruction read, then internal cycle
`timescale 1ns/1ps
`include "csbos_params.svh"

module csbos_sequencer (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Instruction request
  input wire logic start,
  input wire csbos_pkg::csbos_op_t opSel,
  input wire logic [3:0] bitCount,
  input wire logic [15:0] pcIn,
  input wire logic [15:0] wpIn,
  input wire logic [15:0] statusIn,
  // Operand fetch unit
  output csbos_pkg::csbos_state_t stateOut,
  output logic operandFetchStart,
  input wire logic operandFetchDone,
  input wire logic [15:0] sourceOperandValue,
  input wire logic [15:0] sourceOperandAddress,
  // Memory bus
  output csbos_pkg::csbos_bus_t bus,
  input wire logic [15:0] dataLinesIn,
  // Serial bit output
  output csbos_pkg::csbos_serial_t serial,
  // Results
  output logic [15:0] instrWord,
  output logic [15:0] newPc,
  output logic pcLoad,
  output logic [15:0] newWp,
  output logic wpLoad,
  output logic busy,
  output logic done
);
  import csbos_pkg::*;

  csbos_state_t stateQ, stateD;
  csbos_op_t opQ, opD;
  csbos_bus_t busQ, busD;
  csbos_serial_t serQ, serD;
  logic [4:0] cntQ, cntD, cntTotQ, cntTotD;
  logic [15:0] pcQ, pcD, wpQ, wpD, statQ, statD, srcQ, srcD, srcAddrQ, srcAddrD;
  logic [15:0] shiftQ, shiftD, instrQ, instrD, newPcQ, newPcD, newWpQ, newWpD;
  logic fetchStartQ, fetchStartD, pcLoadQ, pcLoadD, wpLoadQ, wpLoadD;
  logic busyQ, busyD, doneQ, doneD;

  always_comb begin
    stateD = stateQ;
    opD = opQ;
    busD = busQ;
    busD.memRead = 1'b0;
    busD.memWrite = 1'b0;
    busD.dataLinesOe = 1'b0;
    serD.serialBitOut = serQ.serialBitOut;
    serD.serialBitStrobe = 1'b0;
    cntD = cntQ;
    cntTotD = cntTotQ;
    pcD = pcQ;
    wpD = wpQ;
    statD = statQ;
    srcD = srcQ;
    srcAddrD = srcAddrQ;
    shiftD = shiftQ;
    instrD = instrQ;
    newPcD = newPcQ;
    newWpD = newWpQ;
    fetchStartD = 1'b0;
    pcLoadD = 1'b0;
    wpLoadD = 1'b0;
    doneD = 1'b0;
    unique case (stateQ)
      ST_IDLE: begin
        if (start) begin
          stateD = ST_FETCH;
          opD = opSel;
          pcD = pcIn;
          wpD = wpIn;
          statD = statusIn;
          cntD = (bitCount == 4'h0) ? `CSBOS_CNT_FULL : {1'b0, bitCount};
          cntTotD = (bitCount == 4'h0) ? `CSBOS_CNT_FULL : {1'b0, bitCount};
          busD.addressLines = pcIn;
          busD.memRead = 1'b1;
        end
      end
      ST_FETCH: begin
        instrD = dataLinesIn;
        stateD = ST_DECODE;
      end
      ST_DECODE: begin
        stateD = ST_OPND;
        fetchStartD = 1'b1;
      end
      ST_OPND: begin
        if (operandFetchDone) begin
          srcD = sourceOperandValue;
          srcAddrD = sourceOperandAddress;
          stateD = ST_ALU3;
        end
      end
      ST_ALU3: begin
        if (opQ == OP_CONTEXT_SWITCH) begin
          stateD = ST_CS4;
          busD.addressLines = srcQ + `CSBOS_SAVED_STATUS_SLOT_OFS;
        end else begin
          stateD = ST_LD4;
        end
      end
      ST_CS4: begin
        stateD = ST_CS5;
        busD.memWrite = 1'b1;
        busD.dataLinesOe = 1'b1;
        busD.dataLinesOut = statQ;
      end
      ST_CS5: begin
        stateD = ST_CS6;
        busD.dataLinesOe = 1'b1;
        busD.dataLinesOut = pcQ + `CSBOS_WORD_STEP;
      end
      ST_CS6: begin
        stateD = ST_CS7;
        busD.addressLines = srcQ + `CSBOS_WR14_OFS;
        busD.memWrite = 1'b1;
        busD.dataLinesOe = 1'b1;
      end
      ST_CS7: begin
        stateD = ST_CS8;
        busD.addressLines = srcQ + `CSBOS_WR13_OFS;
      end
      ST_CS8: begin
        stateD = ST_CS9;
        busD.memWrite = 1'b1;
        busD.dataLinesOe = 1'b1;
        busD.dataLinesOut = wpQ;
      end
      ST_CS9: stateD = ST_CS10;
      ST_CS10: begin
        stateD = ST_CS11;
        busD.addressLines = srcAddrQ + `CSBOS_WORD_STEP;
        busD.memRead = 1'b1;
      end
      ST_CS11: begin
        stateD = ST_CS12;
        newPcD = dataLinesIn;
        pcLoadD = 1'b1;
        newWpD = srcQ;
        wpLoadD = 1'b1;
      end
      ST_CS12: begin
        stateD = ST_IDLE;
        doneD = 1'b1;
      end
      ST_LD4: begin
        stateD = ST_LD5;
        busD.addressLines = wpQ + `CSBOS_BIT_BASE_WORKSPACE_REG_OFS;
      end
      ST_LD5: stateD = ST_LD6;
      ST_LD6: begin
        stateD = ST_LD7;
        busD.memRead = 1'b1;
      end
      ST_LD7: begin
        stateD = ST_LD8;
        shiftD = dataLinesIn;
      end
      ST_LD8: begin
        stateD = ST_LBIT;
        busD.addressLines = shiftQ;
        serD.serialBitOut = srcQ[0];
        serD.serialBitStrobe = 1'b1;
        shiftD = {1'b0, srcQ[15:1]};
      end
      ST_LBIT: begin
        if (cntQ > `CSBOS_CNT_ONE) begin
          cntD = cntQ - `CSBOS_CNT_ONE;
          busD.addressLines = busQ.addressLines + `CSBOS_BIT_STEP;
          serD.serialBitOut = shiftQ[0];
          serD.serialBitStrobe = 1'b1;
          shiftD = {1'b0, shiftQ[15:1]};
        end else if (cntQ == `CSBOS_CNT_ONE) begin
          // Last bit went out; one quiet cycle still follows it
          cntD = `CSBOS_CNT_ZERO;
        end else begin
          stateD = ST_IDLE;
          doneD = 1'b1;
        end
      end
      default: stateD = ST_IDLE;
    endcase
    busyD = (stateD != ST_IDLE);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      stateQ <= ST_IDLE;
      opQ <= OP_CONTEXT_SWITCH;
      busQ <= '0;
      serQ <= '0;
      cntQ <= `CSBOS_CNT_ZERO;
      cntTotQ <= `CSBOS_CNT_ZERO;
      pcQ <= `CSBOS_WORD_ZERO;
      wpQ <= `CSBOS_WORD_ZERO;
      statQ <= `CSBOS_WORD_ZERO;
      srcQ <= `CSBOS_WORD_ZERO;
      srcAddrQ <= `CSBOS_WORD_ZERO;
      shiftQ <= `CSBOS_WORD_ZERO;
      instrQ <= `CSBOS_WORD_ZERO;
      newPcQ <= `CSBOS_WORD_ZERO;
      newWpQ <= `CSBOS_WORD_ZERO;
      fetchStartQ <= 1'b0;
      pcLoadQ <= 1'b0;
      wpLoadQ <= 1'b0;
      busyQ <= 1'b0;
      doneQ <= 1'b0;
    end else begin
      stateQ <= stateD;
      opQ <= opD;
      busQ <= busD;
      serQ <= serD;
      cntQ <= cntD;
      cntTotQ <= cntTotD;
      pcQ <= pcD;
      wpQ <= wpD;
      statQ <= statD;
      srcQ <= srcD;
      srcAddrQ <= srcAddrD;
      shiftQ <= shiftD;
      instrQ <= instrD;
      newPcQ <= newPcD;
      newWpQ <= newWpD;
      fetchStartQ <= fetchStartD;
      pcLoadQ <= pcLoadD;
      wpLoadQ <= wpLoadD;
      busyQ <= busyD;
      doneQ <= doneD;
    end
  end

  assign stateOut = stateQ;
  assign operandFetchStart = fetchStartQ;
  assign bus = busQ;
  assign serial = serQ;
  assign instrWord = instrQ;
  assign newPc = newPcQ;
  assign pcLoad = pcLoadQ;
  assign newWp = newWpQ;
  assign wpLoad = wpLoadQ;
  assign busy = busyQ;
  assign done = doneQ;

  // Strobes counted per instruction, for the bit count check
  logic [4:0] strobeCntQ;
  always_ff @(posedge clk) begin
    if (reset || stateQ == ST_IDLE) begin
      strobeCntQ <= `CSBOS_CNT_ZERO;
    end else if (serQ.serialBitStrobe) begin
      strobeCntQ <= strobeCntQ + `CSBOS_CNT_ONE;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_FETCH_FIRST: assert property (
    (stateQ == ST_IDLE && start) |=> busQ.memRead && busQ.addressLines == $past(pcIn)
      ##1 !busQ.memRead && $stable(busQ.addressLines))
    else $error("Instruction read missing or address moved");
  AST_OPND_GAP: assert property (
    (stateQ == ST_DECODE) |=> fetchStartQ && stateQ == ST_OPND)
    else $error("Operand fetch not started after cycle two");
  AST_SAVED_STATUS_SLOT_ADDR: assert property (
    (stateQ == ST_CS4) |-> busQ.addressLines == srcQ + `CSBOS_SAVED_STATUS_SLOT_OFS && !busQ.memWrite && !busQ.memRead)
    else $error("Register 15 address cycle wrong");
  AST_STATUS_SAVE: assert property (
    (stateQ == ST_CS4) |=> busQ.memWrite && busQ.dataLinesOut == statQ && $stable(busQ.addressLines))
    else $error("Status save write wrong");
  AST_PC_SAVE: assert property (
    (stateQ == ST_CS5) |=> !busQ.memWrite && busQ.dataLinesOut == pcQ + `CSBOS_WORD_STEP
      ##1 busQ.memWrite && busQ.addressLines == srcQ + `CSBOS_WR14_OFS)
    else $error("Return address save wrong");
  AST_WP_SAVE: assert property (
    (stateQ == ST_CS7) |=> !busQ.memWrite && busQ.addressLines == srcQ + `CSBOS_WR13_OFS
      ##1 busQ.memWrite && busQ.dataLinesOut == wpQ)
    else $error("Workspace pointer save wrong");
  AST_NEW_PC: assert property (
    (stateQ == ST_CS11) |=> pcLoadQ && newPcQ == $past(dataLinesIn))
    else $error("New program counter not loaded");
  AST_CS_END: assert property (
    (stateQ == ST_CS12) |-> !busQ.memRead && !busQ.memWrite ##1 doneQ && stateQ == ST_IDLE)
    else $error("Context switch end cycle wrong");
  AST_BIT_BASE_WORKSPACE_REG_TWICE: assert property (
    (stateQ == ST_LD4) |=> (busQ.addressLines == wpQ + `CSBOS_BIT_BASE_WORKSPACE_REG_OFS && !busQ.memRead) [*2]
      ##1 busQ.memRead)
    else $error("Bit base register address cycles wrong");
  AST_BIT_STEP: assert property (
    (serQ.serialBitStrobe && $past(serQ.serialBitStrobe))
      |-> busQ.addressLines == $past(busQ.addressLines) + `CSBOS_BIT_STEP)
    else $error("Bit address did not advance by two");
  AST_BIT_COUNT: assert property (
    (stateQ == ST_LBIT && !serQ.serialBitStrobe) |-> strobeCntQ == cntTotQ)
    else $error("Bit transfer count wrong");
  AST_INTERNAL_QUIET: assert property (
    (stateQ == ST_CS10 || stateQ == ST_LD8 || (stateQ == ST_LBIT && cntQ == `CSBOS_CNT_ZERO))
      |-> $stable(busQ.addressLines) && !busQ.memRead && !busQ.memWrite && !serQ.serialBitStrobe)
    else $error("Internal cycle touched the bus");
endmodule // csbos_sequencer

// *** verification/csbos_mem_model.sv ***
// Memory, operand fetch unit and serial bit sink facing the sequencer
`timescale 1ns/1ps

module csbos_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Device side
  input wire csbos_pkg::csbos_bus_t bus,
  input wire csbos_pkg::csbos_serial_t serial,
  input wire csbos_pkg::csbos_state_t stateOut,
  output logic [15:0] dataLinesIn,
  output logic operandFetchDone,
  // Scenario control
  input wire logic [3:0] fetchDelay
);
  import csbos_pkg::*;
  logic [15:0] lastQ = 16'h0000;
  logic [3:0] waitQ = 4'h0;
  logic [31:0] wrLog[$];
  logic [31:0] rdLog[$];
  logic [16:0] bitLog[$];
  int oeMiss = 0;
  // Lines toggle outside reads so a stale word never passes for read data
  assign dataLinesIn = bus.memRead ? (bus.addressLines ^ 16'h5a5a) : ~lastQ;
  assign operandFetchDone = (stateOut == ST_OPND) && (waitQ >= fetchDelay);
  always @(posedge clk) begin
    lastQ <= dataLinesIn;
    waitQ <= (stateOut == ST_OPND && !reset) ? waitQ + 4'h1 : 4'h0;
    if (bus.memWrite) wrLog.push_back({bus.addressLines, bus.dataLinesOut});
    if (bus.memRead) rdLog.push_back({bus.addressLines, dataLinesIn});
    if (bus.memWrite && !bus.dataLinesOe) oeMiss++;
    if (serial.serialBitStrobe) bitLog.push_back({bus.addressLines, serial.serialBitOut});
  end
endmodule // csbos_mem_model

// *** verification/csbos_sequencer_bench.sv ***
// Self-checking bench for the sequencer
`timescale 1ns/1ps

module csbos_sequencer_bench;
  import csbos_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic start = 1'b0;
  csbos_op_t opSel = OP_CONTEXT_SWITCH;
  logic [3:0] bitCount = 4'h0;
  logic [3:0] fetchDelay = 4'h0;
  logic [15:0] pcIn = 16'h0000;
  logic [15:0] wpIn = 16'h0000;
  logic [15:0] statusIn = 16'h0000;
  logic [15:0] opVal = 16'h0000;
  logic [15:0] opAdr = 16'h0000;
  csbos_state_t stateOut;
  logic operandFetchStart, operandFetchDone, pcLoad, wpLoad, busy, done;
  csbos_bus_t bus;
  csbos_serial_t serial;
  logic [15:0] dataLinesIn, instrWord, newPc, newWp;
  int fails = 0;
  int totalChecks = 0;
  int cycles = 0;
  int loadAt;
  int wpAt;

  always #5 clk = ~clk;

  csbos_sequencer csbos_sequencer_i (.clk(clk), .reset(reset), .start(start), .opSel(opSel),
    .bitCount(bitCount), .pcIn(pcIn), .wpIn(wpIn), .statusIn(statusIn), .stateOut(stateOut),
    .operandFetchStart(operandFetchStart), .operandFetchDone(operandFetchDone),
    .sourceOperandValue(opVal), .sourceOperandAddress(opAdr), .bus(bus), .dataLinesIn(dataLinesIn),
    .serial(serial), .instrWord(instrWord), .newPc(newPc), .pcLoad(pcLoad), .newWp(newWp),
    .wpLoad(wpLoad), .busy(busy), .done(done));

  csbos_mem_model csbos_mem_model_i (.clk(clk), .reset(reset), .bus(bus), .serial(serial),
    .stateOut(stateOut), .dataLinesIn(dataLinesIn), .operandFetchDone(operandFetchDone),
    .fetchDelay(fetchDelay));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      fails++;
    end
  endtask

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // One instruction; start is raised again mid-run when poke is set
  task automatic runOp(input csbos_op_t op, input logic [3:0] cnt, input logic [3:0] dly,
                       input logic [15:0] pc, input logic [15:0] wp, input logic [15:0] st,
                       input logic [15:0] val, input logic [15:0] adr, input bit poke, input int expLen);
    int n;
    int busyN;
    csbos_mem_model_i.wrLog.delete();
    csbos_mem_model_i.rdLog.delete();
    csbos_mem_model_i.bitLog.delete();
    loadAt = 0;
    wpAt = 0;
    @(posedge clk);
    opSel <= op;
    bitCount <= cnt;
    fetchDelay <= dly;
    pcIn <= pc;
    wpIn <= wp;
    statusIn <= st;
    opVal <= val;
    opAdr <= adr;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    busyN = 0;
    do begin
      @(posedge clk);
      start <= poke && n == 4;
      #1;
      n++;
      if (pcLoad === 1'b1) loadAt = n;
      if (wpLoad === 1'b1) wpAt = n;
      if (busy === 1'b1) busyN++;
    end while (done !== 1'b1 && n < 200);
    chk("doneCycle", n, expLen);
    chk("busyLen", busyN, expLen - 1);
    chk("instrWord", instrWord, pc ^ 16'h5a5a);
    chk("firstRead", csbos_mem_model_i.rdLog[0], {pc, pc ^ 16'h5a5a});
    chk("readCount", csbos_mem_model_i.rdLog.size(), 2);
  endtask

  task automatic csCase(input logic [3:0] dly, input bit poke);
    runOp(OP_CONTEXT_SWITCH, 4'h0, dly, 16'h1230, 16'h0400, 16'hc00f, 16'h0800, 16'h2000, poke, 13 + dly);
    chk("writeOe", csbos_mem_model_i.oeMiss, 0);
    chk("writeCount", csbos_mem_model_i.wrLog.size(), 3);
    chk("statusWrite", csbos_mem_model_i.wrLog[0], {16'h081e, 16'hc00f});
    chk("returnWrite", csbos_mem_model_i.wrLog[1], {16'h081c, 16'h1232});
    chk("wpWrite", csbos_mem_model_i.wrLog[2], {16'h081a, 16'h0400});
    chk("pcRead", csbos_mem_model_i.rdLog[1], {16'h2002, 16'h2002 ^ 16'h5a5a});
    chk("newPc", newPc, 16'h2002 ^ 16'h5a5a);
    chk("newWp", newWp, 16'h0800);
    chk("loadCycle", loadAt, 12 + dly);
    chk("wpLoadCycle", wpAt, 12 + dly);
  endtask

  task automatic bitCase(input logic [3:0] cnt, input logic [15:0] val, input logic [3:0] dly);
    int c;
    logic [15:0] base;
    c = (cnt == 4'h0) ? 16 : cnt;
    base = 16'h0318 ^ 16'h5a5a;
    runOp(OP_MULTI_BIT_OUTPUT, cnt, dly, 16'h0100, 16'h0300, 16'h0000, val, 16'h0000, 1'b0, 10 + dly + c);
    chk("noLoad", loadAt + wpAt, 0);
    chk("baseRead", csbos_mem_model_i.rdLog[1], {16'h0318, base});
    chk("writeCount", csbos_mem_model_i.wrLog.size(), 0);
    chk("bitCount", csbos_mem_model_i.bitLog.size(), c);
    for (int i = 0; i < c; i++) begin
      chk("bitSlot", csbos_mem_model_i.bitLog[i], {base + 16'(2 * i), val[i]});
    end
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      end_sim();
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    csCase(4'h0, 1'b0);
    csCase(4'h3, 1'b1);
    bitCase(4'h5, 16'h0015, 4'h0);
    bitCase(4'h0, 16'hb38e, 4'h2);
    bitCase(4'h1, 16'h0001, 4'h1);
    end_sim();
  end
endmodule // csbos_sequencer_bench
